// ==== bst_pkg.sv ====
// Boundary-scan test access port: shared constants, codes and state carriers.
// Assumes one TAP per device and a fixed count of scanned pins.
package bst_pkg;

  // Instruction register width and codes
  localparam int           BST_IR_W       = 3;
  localparam logic [2:0]   BST_IR_EXTEST  = 3'h0;
  localparam logic [2:0]   BST_IR_IDCODE  = 3'h1;
  localparam logic [2:0]   BST_IR_SAMPLE  = 3'h2;
  localparam logic [2:0]   BST_IR_CLAMP   = 3'h3;
  localparam logic [2:0]   BST_IR_HIGHZ   = 3'h4;
  localparam logic [2:0]   BST_IR_BYPASS  = 3'h7;
  // Constant loaded in Capture-IR; low two bits are 01
  localparam logic [2:0]   BST_IR_CAPTURE = 3'h1;

  // Identification code fields; version, part and maker values are arbitrary
  localparam logic [3:0]   BST_ID_VERSION = 4'h1;
  localparam logic [15:0]  BST_ID_PART    = 16'h5A5A;
  localparam logic [10:0]  BST_ID_MAKER   = 11'h2AB;
  localparam logic         BST_ID_MARK    = 1'h1;
  localparam logic [31:0]  BST_ID_CODE    = {BST_ID_VERSION, BST_ID_PART, BST_ID_MAKER, BST_ID_MARK};

  // Boundary cells: three per pin (input sample, output data, output enable)
  localparam int           BST_PIN_N      = 4;
  localparam int           BST_CELLS      = 3;
  localparam int           BST_CELL_IN    = 0;
  localparam int           BST_CELL_OUT   = 1;
  localparam int           BST_CELL_OE    = 2;
  localparam int           BST_BSR_W      = BST_PIN_N * BST_CELLS;

  typedef enum logic [3:0] {
    BST_TLR, BST_RTI, BST_SEL_DR, BST_CAP_DR, BST_SHIFT_DR, BST_EXIT1_DR,
    BST_PAUSE_DR, BST_EXIT2_DR, BST_UPD_DR, BST_SEL_IR, BST_CAP_IR,
    BST_SHIFT_IR, BST_EXIT1_IR, BST_PAUSE_IR, BST_EXIT2_IR, BST_UPD_IR
  } bst_state_type;

  typedef enum logic [1:0] {BST_SEL_BSR, BST_SEL_BYP, BST_SEL_IDR} bst_sel_type;
  // Pin mode crosses into the system clock as a level. Mission and drive differ in both bits,
  // so a skewed sample can only show high impedance or the unused code, which decodes as mission.
  typedef enum logic [1:0] {
    BST_MODE_MISSION = 2'h0,
    BST_MODE_HIGHZ   = 2'h1,
    BST_MODE_DRIVE   = 2'h3
  } bst_mode_type;

  // Pin drive carrier: data and enable per pin
  typedef struct packed {
    logic [BST_PIN_N-1:0] drive;
    logic [BST_PIN_N-1:0] enable;
  } bst_pins_type;

  // Rising test-clock state
  typedef struct packed {
    bst_state_type        state;
    logic [BST_IR_W-1:0]  ir_shift;
    logic [BST_BSR_W-1:0] bsr_shift;
    logic [31:0]          id_shift;
    logic                 byp;
    logic [BST_PIN_N-1:0] pin_meta;
    logic [BST_PIN_N-1:0] pin_smp;
    bst_pins_type         core_meta;
    bst_pins_type         core_smp;
  } bst_tck_type;

  // Falling test-clock state
  typedef struct packed {
    logic [BST_IR_W-1:0]  ir_active;
    logic [BST_BSR_W-1:0] bsr_latch;
    logic [31:0]          id_latch;
    logic                 upd_tgl;
    bst_mode_type         mode;
    logic                 tdo;
    logic                 tdo_oe;
  } bst_neg_type;

  // System clock state
  typedef struct packed {
    bst_mode_type         mode_meta;
    bst_mode_type         mode_sync;
    logic                 tgl_meta;
    logic                 tgl_sync;
    logic                 tgl_seen;
    bst_pins_type         bs_word;
    logic [BST_PIN_N-1:0] pin_meta;
    logic [BST_PIN_N-1:0] pin_sync;
    bst_pins_type         pins;
  } bst_sys_type;

  localparam bst_tck_type BST_TCK_RESET = '{state: BST_TLR, default: '0};
  localparam bst_neg_type BST_NEG_RESET = '{ir_active: BST_IR_IDCODE, mode: BST_MODE_MISSION, default: '0};
  localparam bst_sys_type BST_SYS_RESET = '{mode_meta: BST_MODE_MISSION, mode_sync: BST_MODE_MISSION,
                                           default: '0};

endpackage : bst_pkg

// ==== bst_tap.sv ====
// Boundary-scan TAP: controller, instruction register, bypass, ID and
// boundary registers, plus the pin multiplexer on the system clock.
// Assumes test_mode_select and test_data_in are set up to test_clock by the
// tester, and that mission logic presents pin drive on clock_in.
`timescale 1ns/1ps

// Overview of operation
// R1 - State machine samples test_mode_select on each rising test_clock edge.
// R2 - Power-up in Test-Logic-Reset with identification instruction; mission logic runs.
// R3 - Run-Test-Idle: instruction and data registers hold.
// R4 - Select-DR-Scan: low to Capture-DR, high to Select-IR-Scan; registers hold.
// R5 - Capture-DR loads the selected register if it supports loading; low Shift, high Exit1.
// R6 - Shift-DR shifts selected register from test_data_in toward test_data_out.
// R7 - Exit1-DR: high to Update-DR, low to Pause-DR.
// R8 - Pause-DR holds; stays on low, high goes to Exit2-DR.
// R9 - Exit2-DR: high to Update-DR, low back to Shift-DR.
// R10 - Update-DR falling edge copies shift stages into parallel latches.
// R11 - Select-IR-Scan: low to Capture-IR, high to Test-Logic-Reset; registers hold.
// R12 - Capture-IR loads a fixed constant; high to Exit1-IR, low to Shift-IR.
// R13 - Shift-IR shifts instruction stages on every rising edge, also the one leaving it; stays on low, high to Exit1-IR.
// R14 - Exit1-IR: low to Pause-IR, high to Update-IR.
// R15 - Pause-IR holds; stays on low, high goes to Exit2-IR.
// R16 - Entering Update-IR, the falling edge latches the instruction.
// R17 - Latched instruction becomes active; low to Run-Test-Idle, high to Select-DR-Scan.
// R18 - Instruction register: 3-bit shift stage plus 3-bit parallel latch.
// R19 - Codes 000 and 010 select boundary register; 111 selects bypass.
// R20 - Codes 100 and 011 select bypass; 001 selects identification register.
// R21 - Five port signals: reset, clock, mode select, data in, data out.
// R22 - Bypass is a single stage serial path.
// R23 - Identification register is 32 bits, shift plus latch, bit zero one.
// R24 - High-impedance instruction tri-states every output, bypass on serial path.
// R25 - Clamp drives boundary latch values unchanged, bypass on serial path.
// R26 - Shift-DR high goes to Exit1-DR; Run-Test-Idle high to Select-DR-Scan.
// R27 - Test-Logic-Reset stays on high, low to Run-Test-Idle; reset low forces it.
// R28 - Capture-IR constant has low bits 01.
// R29 - Exit2-IR low returns to Shift-IR.
module bst_tap (
  input  wire logic                       clock_in,
  input  wire logic                       srst_in,
  input  wire logic                       test_clock_in,
  input  wire logic                       test_reset_n_in,
  input  wire logic                       test_mode_select_in,
  input  wire logic                       test_data_in_in,
  output logic                            test_data_out_out,
  output logic                            test_data_oe_out,
  input  wire bst_pkg::bst_pins_type      core_drive_in,
  output bst_pkg::bst_pins_type           pin_bus_out,
  input  wire logic [bst_pkg::BST_PIN_N-1:0] pin_level_in,
  output logic [bst_pkg::BST_PIN_N-1:0]   core_level_out
);
  import bst_pkg::*;

  bst_tck_type tck_reg;
  bst_tck_type tck_next;
  bst_neg_type neg_reg;
  bst_neg_type neg_next;
  bst_sys_type sys_reg;
  bst_sys_type sys_next;

  // Register chosen by an instruction; unknown codes fall back to bypass
  function automatic bst_sel_type bst_select(input logic [BST_IR_W-1:0] ir);
    case (ir)
      BST_IR_EXTEST, BST_IR_SAMPLE: bst_select = BST_SEL_BSR; // [R19]
      BST_IR_IDCODE:                bst_select = BST_SEL_IDR; // [R20]
      BST_IR_BYPASS:                bst_select = BST_SEL_BYP; // [R19]
      BST_IR_CLAMP, BST_IR_HIGHZ:   bst_select = BST_SEL_BYP; // [R20] [R22]
      default:                      bst_select = BST_SEL_BYP;
    endcase
  endfunction : bst_select

  // Pin mode implied by an instruction
  function automatic bst_mode_type bst_mode(input logic [BST_IR_W-1:0] ir);
    case (ir)
      BST_IR_EXTEST, BST_IR_CLAMP: bst_mode = BST_MODE_DRIVE; // [R25]
      BST_IR_HIGHZ:                bst_mode = BST_MODE_HIGHZ; // [R24]
      default:                     bst_mode = BST_MODE_MISSION;
    endcase
  endfunction : bst_mode

  // Controller next state and rising-edge register work
  always_comb
  begin
    tck_next = tck_reg;
    // Pins and core drive reach capture cells through two flops each
    tck_next.pin_meta  = pin_level_in;
    tck_next.pin_smp   = tck_reg.pin_meta;
    tck_next.core_meta = core_drive_in;
    tck_next.core_smp  = tck_reg.core_meta;

    case (tck_reg.state) // [R1]
      BST_TLR:      tck_next.state = test_mode_select_in ? BST_TLR : BST_RTI; // [R27]
      BST_RTI:      tck_next.state = test_mode_select_in ? BST_SEL_DR : BST_RTI; // [R3] [R26]
      BST_SEL_DR:   tck_next.state = test_mode_select_in ? BST_SEL_IR : BST_CAP_DR; // [R4]
      BST_CAP_DR:   tck_next.state = test_mode_select_in ? BST_EXIT1_DR : BST_SHIFT_DR; // [R5]
      BST_SHIFT_DR: tck_next.state = test_mode_select_in ? BST_EXIT1_DR : BST_SHIFT_DR; // [R26]
      BST_EXIT1_DR: tck_next.state = test_mode_select_in ? BST_UPD_DR : BST_PAUSE_DR; // [R7]
      BST_PAUSE_DR: tck_next.state = test_mode_select_in ? BST_EXIT2_DR : BST_PAUSE_DR; // [R8]
      BST_EXIT2_DR: tck_next.state = test_mode_select_in ? BST_UPD_DR : BST_SHIFT_DR; // [R9]
      BST_UPD_DR:   tck_next.state = test_mode_select_in ? BST_SEL_DR : BST_RTI;
      BST_SEL_IR:   tck_next.state = test_mode_select_in ? BST_TLR : BST_CAP_IR; // [R11]
      BST_CAP_IR:   tck_next.state = test_mode_select_in ? BST_EXIT1_IR : BST_SHIFT_IR; // [R12]
      BST_SHIFT_IR: tck_next.state = test_mode_select_in ? BST_EXIT1_IR : BST_SHIFT_IR; // [R13]
      BST_EXIT1_IR: tck_next.state = test_mode_select_in ? BST_UPD_IR : BST_PAUSE_IR; // [R14] [R16]
      BST_PAUSE_IR: tck_next.state = test_mode_select_in ? BST_EXIT2_IR : BST_PAUSE_IR; // [R15]
      BST_EXIT2_IR: tck_next.state = test_mode_select_in ? BST_UPD_IR : BST_SHIFT_IR; // [R16] [R29]
      BST_UPD_IR:   tck_next.state = test_mode_select_in ? BST_SEL_DR : BST_RTI; // [R17]
      default:      tck_next.state = BST_TLR;
    endcase

    // Only capture and shift states touch the shift stages; all others hold
    case (tck_reg.state)
      BST_CAP_IR:
      begin
        tck_next.ir_shift = BST_IR_CAPTURE; // [R12] [R28]
      end
      BST_SHIFT_IR:
      begin
        tck_next.ir_shift = {test_data_in_in, tck_reg.ir_shift[BST_IR_W-1:1]}; // [R13] [R18]
      end
      BST_CAP_DR:
      begin
        case (bst_select(neg_reg.ir_active)) // [R5]
          BST_SEL_BSR:
          begin
            for (int i = 0; i < BST_PIN_N; i++)
            begin
              tck_next.bsr_shift[i*BST_CELLS+BST_CELL_IN]  = tck_reg.pin_smp[i];
              tck_next.bsr_shift[i*BST_CELLS+BST_CELL_OUT] = tck_reg.core_smp.drive[i];
              tck_next.bsr_shift[i*BST_CELLS+BST_CELL_OE]  = tck_reg.core_smp.enable[i];
            end
          end
          BST_SEL_IDR: tck_next.id_shift = BST_ID_CODE; // [R23]
          default:     tck_next.byp = 1'h0; // [R22]
        endcase
      end
      BST_SHIFT_DR:
      begin
        case (bst_select(neg_reg.ir_active)) // [R6]
          BST_SEL_BSR: tck_next.bsr_shift = {test_data_in_in, tck_reg.bsr_shift[BST_BSR_W-1:1]};
          BST_SEL_IDR: tck_next.id_shift = {test_data_in_in, tck_reg.id_shift[31:1]};
          default:     tck_next.byp = test_data_in_in; // [R22]
        endcase
      end
      default:
      begin
        tck_next.ir_shift = tck_reg.ir_shift; // [R3] [R4] [R8] [R11] [R15]
      end
    endcase
  end

  // Test reset acts at once; no other event moves the controller off a clock edge
  always_ff @(posedge test_clock_in or negedge test_reset_n_in)
  begin
    if (!test_reset_n_in)
      tck_reg <= BST_TCK_RESET; // [R2] [R27]
    else
      tck_reg <= tck_next;
  end

  // Falling-edge latches and serial output
  always_comb
  begin
    neg_next = neg_reg;
    case (tck_reg.state)
      BST_TLR:    neg_next.ir_active = BST_IR_IDCODE; // [R2]
      BST_UPD_IR: neg_next.ir_active = tck_reg.ir_shift; // [R16] [R17] [R18]
      BST_UPD_DR:
      begin
        case (bst_select(neg_reg.ir_active)) // [R10]
          BST_SEL_BSR:
          begin
            neg_next.bsr_latch = tck_reg.bsr_shift;
            neg_next.upd_tgl   = ~neg_reg.upd_tgl;
          end
          BST_SEL_IDR: neg_next.id_latch = tck_reg.id_shift; // [R23]
          default:     neg_next.bsr_latch = neg_reg.bsr_latch;
        endcase
      end
      default: neg_next.ir_active = neg_reg.ir_active;
    endcase
    neg_next.mode = bst_mode(neg_next.ir_active);

    // Output changes on the falling edge so the tester samples it clean
    neg_next.tdo_oe = (tck_reg.state == BST_SHIFT_DR) || (tck_reg.state == BST_SHIFT_IR);
    case (tck_reg.state)
      BST_SHIFT_IR: neg_next.tdo = tck_reg.ir_shift[0]; // [R13]
      BST_SHIFT_DR:
      begin
        case (bst_select(neg_reg.ir_active)) // [R6]
          BST_SEL_BSR: neg_next.tdo = tck_reg.bsr_shift[0];
          BST_SEL_IDR: neg_next.tdo = tck_reg.id_shift[0];
          default:     neg_next.tdo = tck_reg.byp; // [R22] [R24] [R25]
        endcase
      end
      default: neg_next.tdo = neg_reg.tdo;
    endcase
  end

  always_ff @(negedge test_clock_in or negedge test_reset_n_in)
  begin
    if (!test_reset_n_in)
      neg_reg <= BST_NEG_RESET; // [R2]
    else
      neg_reg <= neg_next;
  end

  // System side: mode level and update event cross by two flops each.
  // The latch word is read only after the toggle lands, and it cannot move
  // again before a full DR scan, so it is stable when taken.
  always_comb
  begin
    sys_next = sys_reg;
    sys_next.mode_meta = neg_reg.mode;
    sys_next.mode_sync = sys_reg.mode_meta;
    sys_next.tgl_meta  = neg_reg.upd_tgl;
    sys_next.tgl_sync  = sys_reg.tgl_meta;
    sys_next.tgl_seen  = sys_reg.tgl_sync;
    sys_next.pin_meta  = pin_level_in;
    sys_next.pin_sync  = sys_reg.pin_meta;
    if (sys_reg.tgl_sync != sys_reg.tgl_seen)
    begin
      for (int i = 0; i < BST_PIN_N; i++)
      begin
        sys_next.bs_word.drive[i]  = neg_reg.bsr_latch[i*BST_CELLS+BST_CELL_OUT];
        sys_next.bs_word.enable[i] = neg_reg.bsr_latch[i*BST_CELLS+BST_CELL_OE];
      end
    end
    // Mission logic keeps the pins unless a test instruction takes them
    case (sys_reg.mode_sync)
      BST_MODE_DRIVE:  sys_next.pins = sys_reg.bs_word; // [R25]
      BST_MODE_HIGHZ:  sys_next.pins = '{drive: sys_reg.bs_word.drive, enable: '0}; // [R24]
      default:         sys_next.pins = core_drive_in; // [R2]
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      sys_reg <= BST_SYS_RESET;
    else
      sys_reg <= sys_next;
  end

  // Outputs straight from flops
  assign test_data_out_out = neg_reg.tdo; // [R21]
  assign test_data_oe_out  = neg_reg.tdo_oe;
  assign pin_bus_out       = sys_reg.pins;
  assign core_level_out    = sys_reg.pin_sync;

endmodule : bst_tap

// ==== bst_tap_properties.sv ====
// Port-level checker for the boundary-scan TAP.
// Assumes nothing of the test clock during test reset; the shadow clears at once when reset asserts.
`timescale 1ns/1ps
module bst_tap_properties
  import bst_pkg::*;
(
  input wire logic                      clock_in,
  input wire logic                      srst_in,
  input wire logic                      test_clock_in,
  input wire logic                      test_reset_n_in,
  input wire logic                      test_mode_select_in,
  input wire logic                      test_data_in_in,
  input wire logic                      test_data_out_out,
  input wire logic                      test_data_oe_out,
  input wire bst_pkg::bst_pins_type     core_drive_in,
  input wire bst_pkg::bst_pins_type     pin_bus_out,
  input wire logic [BST_PIN_N-1:0]      pin_level_in,
  input wire logic [BST_PIN_N-1:0]      core_level_out
);
  // Next state per current state, one nibble each, for mode select high and low
  localparam logic [63:0] NXT_HI = 64'h2FEFCC0287855920;
  localparam logic [63:0] NXT_LO = 64'h1BDDBBA146644311;
  logic [3:0] st_reg;
  logic [2:0] irs_reg;
  logic [2:0] ir_reg;
  logic       byp;
  logic       hz;
  logic       idm;
  assign byp = (ir_reg > 3'h2);
  assign hz  = (ir_reg == 3'h4);
  assign idm = (ir_reg == 3'h1);
  // Shadow of state and instruction, rebuilt from the tester's own pins
  always_ff @(posedge test_clock_in or negedge test_reset_n_in)
    if (!test_reset_n_in)
    begin
      st_reg  <= 4'h0;
      irs_reg <= 3'h0;
      ir_reg  <= 3'h1;
    end
    else
    begin
      st_reg <= test_mode_select_in ? NXT_HI[{st_reg, 2'b00} +: 4] : NXT_LO[{st_reg, 2'b00} +: 4];
      if (st_reg == 4'hA)
        irs_reg <= 3'h1;
      else if (st_reg == 4'hB)
        irs_reg <= {test_data_in_in, irs_reg[2:1]};
      if (st_reg == 4'h0)
        ir_reg <= 3'h1;
      else if ((st_reg == 4'hC || st_reg == 4'hE) && test_mode_select_in)
        ir_reg <= irs_reg;
    end
  chk_oe_in_shift: assert property (@(posedge test_clock_in) disable iff (!test_reset_n_in)
    test_data_oe_out == (st_reg == 4'h4 || st_reg == 4'hB)) else $error("data out enable outside shift");
  chk_tdo_holds: assert property (@(posedge test_clock_in) disable iff (!test_reset_n_in)
    (st_reg != 4'h4 && st_reg != 4'hB) |-> $stable(test_data_out_out)) else $error("data out moved");
  chk_ir_capture: assert property (@(posedge test_clock_in) disable iff (!test_reset_n_in)
    (st_reg == 4'hA && !test_mode_select_in) |=> test_data_out_out ##1 (st_reg != 4'hB || !test_data_out_out))
    else $error("instruction capture bits wrong");
  chk_id_mark: assert property (@(posedge test_clock_in) disable iff (!test_reset_n_in)
    (idm && st_reg == 4'h3 && !test_mode_select_in) |=> test_data_out_out) else $error("id bit zero not one");
  chk_byp_capture: assert property (@(posedge test_clock_in) disable iff (!test_reset_n_in)
    (byp && st_reg == 4'h3 && !test_mode_select_in) |=> !test_data_out_out) else $error("bypass capture");
  chk_byp_path: assert property (@(posedge test_clock_in) disable iff (!test_reset_n_in)
    (byp && st_reg == 4'h4 && $past(st_reg) == 4'h4) |-> test_data_out_out == $past(test_data_in_in))
    else $error("bypass path not one stage");
  chk_mission_pins: assert property (@(posedge clock_in) disable iff (srst_in)
    (idm && $past(idm, 8) && !$past(srst_in)) |-> pin_bus_out == $past(core_drive_in))
    else $error("pins do not follow mission drive");
  chk_highz_pins: assert property (@(posedge clock_in) disable iff (srst_in)
    (hz && $past(hz, 8)) |-> pin_bus_out.enable == 4'h0) else $error("pin enabled under high impedance");
endmodule : bst_tap_properties
bind bst_tap bst_tap_properties bst_tap_properties_i (.clock_in(clock_in), .srst_in(srst_in),
  .test_clock_in(test_clock_in), .test_reset_n_in(test_reset_n_in), .test_mode_select_in(test_mode_select_in),
  .test_data_in_in(test_data_in_in), .test_data_out_out(test_data_out_out), .test_data_oe_out(test_data_oe_out),
  .core_drive_in(core_drive_in), .pin_bus_out(pin_bus_out), .pin_level_in(pin_level_in),
  .core_level_out(core_level_out));

// ==== bst_tester.sv ====
// Model of the external boundary-scan tester.
// Assumes one task at a time; the test clock stands still between calls.
`timescale 1ns/1ps
module bst_tester (
  output logic      test_clock_out,
  output logic      test_reset_n_out,
  output logic      test_mode_select_out,
  output logic      test_data_in_out,
  input  wire logic test_data_out_in,
  input  wire logic test_data_oe_in
);
  logic seen_reg;
  // Idle pins: clock low, mode select high, reset released
  initial
  begin
    test_clock_out       = 1'b0;
    test_reset_n_out     = 1'b1;
    test_mode_select_out = 1'b1;
    test_data_in_out     = 1'b0;
    seen_reg             = 1'b0;
  end
  // One 125 ns period; data out is read before the rise, inputs set up half a period ahead
  task automatic tick(input logic mode, input logic data, output logic seen);
    seen_reg = test_data_oe_in ? test_data_out_in : ~seen_reg; // Undriven line reads as noise
    seen = seen_reg;
    test_mode_select_out = mode;
    test_data_in_out = data;
    #62.0;
    test_clock_out = 1'b1;
    #0.5;
    test_data_in_out = ~data; // Data line stops showing the bit once the rise has taken it
    #62.0;
    test_clock_out = 1'b0;
    #0.5;
  endtask : tick
  // Test reset pulse with the clock standing still
  task automatic pulse_reset();
    #10.0;
    test_reset_n_out = 1'b0;
    #20.0;
    test_reset_n_out = 1'b1;
    #10.0;
  endtask : pulse_reset
  // Reset with the clock running keeps every edge inside the reset window
  task automatic reset_tap();
    logic q;
    test_reset_n_out = 1'b0;
    tick(1'b1, 1'b0, q);
    tick(1'b1, 1'b0, q);
    test_reset_n_out = 1'b1;
  endtask : reset_tap
endmodule : bst_tester

// ==== tb.sv ====
// Self-checking bench for the boundary-scan TAP with a tester model.
// Assumes test clock at 125 ns, system clock at 40 ns, unrelated in phase.
`timescale 1ns/1ps
module tb;
  import bst_pkg::*;
  logic                 clock_in = 1'b0;
  logic                 srst_in = 1'b1;
  logic                 tck, trst_n, tms, tdi, tdo, oe;
  bst_pins_type         core_drive = 8'h00;
  bst_pins_type         pins;
  logic [BST_PIN_N-1:0] level = 4'h0;
  logic [BST_PIN_N-1:0] core_level;
  logic [31:0]          d, e;
  logic                 q;
  int                   err_total = 0;
  int                   n_checks = 0;
  always #20 clock_in = ~clock_in;
  bst_tap bst_tap_i (.clock_in(clock_in), .srst_in(srst_in), .test_clock_in(tck), .test_reset_n_in(trst_n),
    .test_mode_select_in(tms), .test_data_in_in(tdi), .test_data_out_out(tdo), .test_data_oe_out(oe),
    .core_drive_in(core_drive), .pin_bus_out(pins), .pin_level_in(level), .core_level_out(core_level));
  bst_tester bst_tester_i (.test_clock_out(tck), .test_reset_n_out(trst_n), .test_mode_select_out(tms),
    .test_data_in_out(tdi), .test_data_out_in(tdo), .test_data_oe_in(oe));
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s at %0t: got %h want %h", what, $time, got, exp);
    end
  endtask : cmp
  task automatic moves(input logic [7:0] seq, input int n);
    for (int i = 0; i < n; i++)
      bst_tester_i.tick(seq[i], 1'b0, q);
  endtask : moves
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = 32'h0;
    for (int i = 0; i < n; i++)
      bst_tester_i.tick(i == n - 1, din[i], dout[i]);
  endtask : shift
  task automatic load_ir(input logic [2:0] code);
    moves(8'h03, 4);
    shift(3, {29'h0, code}, d);
    cmp(d, 32'h1, "instruction capture");
    moves(8'h01, 2);
  endtask : load_ir
  task automatic scan_dr(input int n, input logic [31:0] din);
    moves(8'h01, 3);
    shift(n, din, d);
    moves(8'h01, 2);
  endtask : scan_dr
  // Pin word expected from a boundary pattern: drive cell 3i+1, enable cell 3i+2
  function automatic bst_pins_type pins_of(input logic [31:0] v, input logic hiz);
    for (int i = 0; i < BST_PIN_N; i++)
    begin
      pins_of.drive[i]  = v[3*i+1];
      pins_of.enable[i] = v[3*i+2] & ~hiz;
    end
  endfunction : pins_of
  task automatic pins_are(input bst_pins_type exp);
    repeat (10) @(negedge clock_in);
    cmp(pins, exp, "pin word");
  endtask : pins_are
  task automatic t_idcode();
    scan_dr(32, 32'h0);
    cmp(d, BST_ID_CODE, "id code");
  endtask : t_idcode
  task automatic t_mission();
    @(posedge clock_in);
    core_drive <= 8'hA5;
    level <= 4'h9;
    pins_are(8'hA5);
    cmp(core_level, 4'h9, "level sync");
  endtask : t_mission
  task automatic t_ir_pause();
    moves(8'h03, 4);
    shift(2, 32'h3, d);
    moves(8'h04, 4);
    shift(1, 32'h1, e);
    cmp({e[0], d[1:0]}, 32'h1, "paused capture");
    moves(8'h01, 2);
    scan_dr(4, 32'hB);
    cmp(d, 32'h6, "bypass after pause");
  endtask : t_ir_pause
  task automatic t_bypass_codes();
    logic [2:0] codes [4] = '{BST_IR_CLAMP, BST_IR_HIGHZ, BST_IR_BYPASS, 3'h5};
    foreach (codes[k])
    begin
      load_ir(codes[k]);
      scan_dr(4, 32'hB);
      cmp(d, 32'h6, "one stage path");
    end
  endtask : t_bypass_codes
  task automatic t_boundary();
    e = 32'h0;
    for (int i = 0; i < BST_PIN_N; i++)
      e[3*i +: 3] = {core_drive.enable[i], core_drive.drive[i], level[i]};
    load_ir(BST_IR_SAMPLE);
    scan_dr(12, 32'h6B9);
    cmp(d, e, "boundary capture");
    pins_are(core_drive);
    load_ir(BST_IR_EXTEST);
    pins_are(pins_of(32'h6B9, 1'b0));
    moves(8'h01, 3);
    shift(12, 32'h96E, d);
    cmp(d, e, "extest capture");
    moves(8'h00, 2);
    pins_are(pins_of(32'h6B9, 1'b0));
    moves(8'h03, 3);
    pins_are(pins_of(32'h96E, 1'b0));
    load_ir(BST_IR_CLAMP);
    pins_are(pins_of(32'h96E, 1'b0));
    load_ir(BST_IR_HIGHZ);
    pins_are(pins_of(32'h96E, 1'b1));
  endtask : t_boundary
  task automatic t_back_to_reset();
    moves(8'h1F, 6);
    t_idcode();
    pins_are(core_drive);
  endtask : t_back_to_reset
  // Reset from Shift-DR with no clock; only the asynchronous reset can restore the ID instruction
  task automatic t_async_reset();
    load_ir(BST_IR_BYPASS);
    moves(8'h01, 3);
    bst_tester_i.pulse_reset();
    moves(8'h00, 1);
    t_idcode();
  endtask : t_async_reset
  // Watchdog sized well above the roughly 41 us of scans
  initial
  begin
    #400000;
    err_total++;
    give_verdict();
  end
  initial
  begin
    repeat (4) @(posedge clock_in);
    srst_in <= 1'b0;
    bst_tester_i.reset_tap();
    moves(8'h00, 1);
    t_idcode();
    t_mission();
    t_ir_pause();
    t_bypass_codes();
    t_boundary();
    t_back_to_reset();
    t_async_reset();
    give_verdict();
  end
endmodule : tb
